//--- ciao_int_accum.v
// decode and execute of integer and accumulator arithmetic instructions
// assumes the host issues one valid-qualified word per cycle, condition already passed
// Function
// - sub 001 in group 0101 opcode 0011: dest gets 64-bit absolute value of source
// - sub 010: dest gets 32-bit negation of source
// - sub 011: dest gets 64-bit negation of source
// - sub 100: dest gets 32-bit sum of two sources
// - sub 101: dest gets 64-bit sum of two sources
// - sub 110: dest gets 32-bit first source minus second source
// - sub 111: dest gets 64-bit first source minus second source
// - opcode 0001 sub 000: dest gets 32-bit product of sources
// - opcode 0001 sub 001: dest gets 64-bit product of sources
// - opcode 0001 sub 010: dest plus 32-bit product written back to dest
// - opcode 0001 sub 011: dest minus 32-bit product written back to dest
// - group 0110 opcode 0000: register plus product into selected accumulator
// - group 0110 opcode 0001: register minus product into selected accumulator
// - group 0110 opcode 0010: accumulator plus product into selected accumulator
// - group 0110 opcode 0011: accumulator minus product into selected accumulator
// - accumulator result index comes from bits 6:5 of the bits 7:5 field, never bits 15:12
`include "ciao_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module ciao_int_accum #(
  parameter NREG = 16,
  parameter NACC = 4
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // instruction from host
  input wire instrValid,
  input wire [31:0] instr,
  // register load from host
  input wire loadValid,
  input wire [3:0] loadSel,
  input wire [63:0] loadData,
  // result view
  input wire [3:0] readSel,
  output reg [63:0] readData,
  output reg done,
  output reg undef
);

  // =========================================
  // storage
  reg [63:0] regFile [0:NREG-1];
  reg [63:0] accFile [0:NACC-1];

  // =========================================
  // field extraction
  wire [3:0] classF = instr[`CIAO_CLASS_HI:`CIAO_CLASS_LO];
  wire [3:0] opcF = instr[`CIAO_OPC_HI:`CIAO_OPC_LO];
  wire [3:0] grpF = instr[`CIAO_GRP_HI:`CIAO_GRP_LO];
  wire [2:0] subF = instr[`CIAO_SUB_HI:`CIAO_SUB_LO];
  wire bit4 = instr[`CIAO_BIT4];
  wire [3:0] firstSourceField = instr[`CIAO_SRC1_HI:`CIAO_SRC1_LO];
  wire [3:0] secondSourceField = instr[`CIAO_SRC2_HI:`CIAO_SRC2_LO];
  wire [3:0] destRegField = instr[`CIAO_DST_HI:`CIAO_DST_LO];
  wire [2:0] destAccumulatorField = subF;

  wire [63:0] srcA = regFile[firstSourceField];
  wire [63:0] srcB = regFile[secondSourceField];
  wire [63:0] dstOld = regFile[destRegField];
  wire [63:0] accOld = accFile[destRegField[1:0]];
  wire [31:0] prod32 = srcA[31:0] * srcB[31:0];
  wire [63:0] prod64 = srcA * srcB;

  // =========================================
  // per-operation results
  wire [63:0] absRes = srcA[63] ? (64'h0 - srcA) : srcA;
  wire [31:0] neg32 = 32'h0 - srcA[31:0];
  wire [63:0] neg64 = 64'h0 - srcA;
  wire [31:0] add32 = srcA[31:0] + srcB[31:0];
  wire [63:0] add64 = srcA + srcB;
  wire [31:0] sub32 = srcA[31:0] - srcB[31:0];
  wire [63:0] sub64 = srcA - srcB;
  wire [31:0] mac32 = dstOld[31:0] + prod32;
  wire [31:0] msc32 = dstOld[31:0] - prod32;
  wire [31:0] accMac32 = accOld[31:0] + prod32;
  wire [31:0] accMsc32 = accOld[31:0] - prod32;

  // =========================================
  // 32-bit results land zero-extended in the low half
  wire [63:0] neg32Ext = {32'h0, neg32};
  wire [63:0] add32Ext = {32'h0, add32};
  wire [63:0] sub32Ext = {32'h0, sub32};
  wire [63:0] mul32Ext = {32'h0, prod32};
  wire [63:0] mac32Ext = {32'h0, mac32};
  wire [63:0] msc32Ext = {32'h0, msc32};
  wire [63:0] accMac32Ext = {32'h0, accMac32};
  wire [63:0] accMsc32Ext = {32'h0, accMsc32};

  // =========================================
  // group decode
  wire isData = instrValid && classF == `CIAO_CLASS_DATA;
  wire isIntGrp = isData && grpF == `CIAO_GRP_INT;
  wire isAccGrp = isData && grpF == `CIAO_GRP_ACC;
  wire isArith = isIntGrp && !bit4 && opcF == `CIAO_OPC_ARITH;
  wire isMul = isIntGrp && !bit4 && opcF == `CIAO_OPC_MUL;
  wire isAccOp = isAccGrp && !bit4;
  // bit 4 set in the integer group is a compare for another unit
  wire isAccBad = isAccGrp && bit4;

  // =========================================
  // decode and compute
  reg next_wrReg;
  reg next_wrAcc;
  reg next_undef;
  reg [63:0] next_result;

  always @*
  begin
    next_wrReg = 1'b0;
    next_wrAcc = 1'b0;
    next_undef = 1'b0;
    next_result = 64'h0;
    if (isArith)
    begin
      next_wrReg = 1'b1;
      case (subF)
        `CIAO_SUB_ABS64:
        begin
          next_result = absRes;
        end
        `CIAO_SUB_NEG32:
        begin
          next_result = neg32Ext;
        end
        `CIAO_SUB_NEG64:
        begin
          next_result = neg64;
        end
        `CIAO_SUB_ADD32:
        begin
          next_result = add32Ext;
        end
        `CIAO_SUB_ADD64:
        begin
          next_result = add64;
        end
        `CIAO_SUB_SUB32:
        begin
          next_result = sub32Ext;
        end
        `CIAO_SUB_SUB64:
        begin
          next_result = sub64;
        end
        default:
        begin
          // sub 000, the 32-bit absolute value, is not decoded and is flagged undefined
          next_wrReg = 1'b0;
          next_undef = 1'b1;
        end
      endcase
    end
    else if (isMul)
    begin
      next_wrReg = 1'b1;
      case (subF)
        `CIAO_SUB_MUL32:
        begin
          next_result = mul32Ext;
        end
        `CIAO_SUB_MUL64:
        begin
          next_result = prod64;
        end
        `CIAO_SUB_MAC32:
        begin
          next_result = mac32Ext;
        end
        `CIAO_SUB_MSC32:
        begin
          next_result = msc32Ext;
        end
        default:
        begin
          next_wrReg = 1'b0;
          next_undef = 1'b1;
        end
      endcase
    end
    else if (isAccOp)
    begin
      next_wrAcc = 1'b1;
      case (opcF)
        `CIAO_OPC_MADD_ACC:
        begin
          next_result = mac32Ext;
        end
        `CIAO_OPC_MSUB_ACC:
        begin
          next_result = msc32Ext;
        end
        `CIAO_OPC_AMADD:
        begin
          next_result = accMac32Ext;
        end
        `CIAO_OPC_AMSUB:
        begin
          next_result = accMsc32Ext;
        end
        default:
        begin
          next_wrAcc = 1'b0;
          next_undef = 1'b1;
        end
      endcase
    end
    else if (isAccBad)
    begin
      next_undef = 1'b1;
    end
  end

  // =========================================
  // host load path
  wire loadReg = loadValid && !loadSel[3];
  wire loadAcc = loadValid && loadSel[3];
  wire [3:0] loadRegIdx = {1'b0, loadSel[2:0]};

  // =========================================
  // register file update
  // an instruction and a load to one register in one cycle: the instruction wins
  integer i;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (i = 0; i < NREG; i = i + 1)
        regFile[i] <= `CIAO_REG_RST;
    end
    else
    begin
      if (loadReg)
        regFile[loadRegIdx] <= loadData;
      if (next_wrReg)
        regFile[destRegField] <= next_result;
    end
  end

  // =========================================
  // accumulator update
  // only the low index bits reach the four accumulators
  integer j;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (j = 0; j < NACC; j = j + 1)
        accFile[j] <= `CIAO_REG_RST;
    end
    else
    begin
      if (loadAcc)
        accFile[loadSel[1:0]] <= loadData;
      if (next_wrAcc)
        accFile[destAccumulatorField[1:0]] <= next_result;
    end
  end

  // =========================================
  // read port select
  wire [63:0] regView = regFile[readSel];
  wire [63:0] accView = accFile[readSel[1:0]];
  wire [63:0] readView = readSel[3] ? accView : regView;

  // =========================================
  // status outputs
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      done <= 1'b0;
      undef <= 1'b0;
    end
    else
    begin
      done <= next_wrReg | next_wrAcc;
      undef <= next_undef;
    end
  end

  // =========================================
  // read data output
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      readData <= `CIAO_REG_RST;
    end
    else
    begin
      readData <= readView;
    end
  end

endmodule
`default_nettype wire

//--- ciao_regs.vh
// constants for the coprocessor integer and accumulator arithmetic decoder
// assumes a 32-bit instruction word in the coprocessor data format
`ifndef CIAO_REGS_VH
`define CIAO_REGS_VH
// field positions
`define CIAO_COND_HI 31
`define CIAO_COND_LO 28
`define CIAO_CLASS_HI 27
`define CIAO_CLASS_LO 24
`define CIAO_OPC_HI 23
`define CIAO_OPC_LO 20
`define CIAO_SRC1_HI 19
`define CIAO_SRC1_LO 16
`define CIAO_DST_HI 15
`define CIAO_DST_LO 12
`define CIAO_GRP_HI 11
`define CIAO_GRP_LO 8
`define CIAO_SUB_HI 7
`define CIAO_SUB_LO 5
`define CIAO_BIT4 4
`define CIAO_SRC2_HI 3
`define CIAO_SRC2_LO 0
// encodings
`define CIAO_CLASS_DATA 4'he
`define CIAO_GRP_INT 4'h5
`define CIAO_GRP_ACC 4'h6
`define CIAO_OPC_ARITH 4'h3
`define CIAO_OPC_MUL 4'h1
`define CIAO_OPC_MADD_ACC 4'h0
`define CIAO_OPC_MSUB_ACC 4'h1
`define CIAO_OPC_AMADD 4'h2
`define CIAO_OPC_AMSUB 4'h3
`define CIAO_SUB_ABS64 3'h1
`define CIAO_SUB_NEG32 3'h2
`define CIAO_SUB_NEG64 3'h3
`define CIAO_SUB_ADD32 3'h4
`define CIAO_SUB_ADD64 3'h5
`define CIAO_SUB_SUB32 3'h6
`define CIAO_SUB_SUB64 3'h7
`define CIAO_SUB_MUL32 3'h0
`define CIAO_SUB_MUL64 3'h1
`define CIAO_SUB_MAC32 3'h2
`define CIAO_SUB_MSC32 3'h3
// reset values
`define CIAO_REG_RST 64'h0
`endif

//--- ciao_int_accum_monitor.sv
// checker on the decoder ports
// assumes it is bound into ciao_int_accum
`timescale 1ns/1ps
`default_nettype none
module ciao_int_accum_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // watched ports
  input wire logic instrValid,
  input wire logic [31:0] instr,
  input wire logic loadValid,
  input wire logic [3:0] readSel,
  input wire logic [63:0] readData,
  input wire logic done,
  input wire logic undef
);
  // ==========
  // decode
  wire v = instrValid && instr[27:24] == 4'he;
  wire [3:0] op = instr[23:20];
  wire [2:0] sb = instr[7:5];
  wire g5 = v && instr[11:8] == 4'h5 && !instr[4];
  wire g6 = v && instr[11:8] == 4'h6;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ar; g5 && op == 4'h3 && sb != 3'h0 |=> done && !undef; endproperty
  a_ar: assert property (p_ar) else $error("arith op not done");
  property p_mu; g5 && op == 4'h1 && !sb[2] |=> done && !undef; endproperty
  a_mu: assert property (p_mu) else $error("mul op not done");
  property p_ac; g6 && !instr[4] && op[3:2] == 2'h0 |=> done && !undef; endproperty
  a_ac: assert property (p_ac) else $error("acc op not done");
  property p_u6; g6 && instr[4] |=> undef && !done; endproperty
  a_u6: assert property (p_u6) else $error("acc bit4 not undef");
  property p_ab; g5 && op == 4'h3 && sb == 3'h0 |=> undef; endproperty
  a_ab: assert property (p_ab) else $error("abs32 not undef");
  property p_ot; instrValid && !v |=> !done && !undef; endproperty
  a_ot: assert property (p_ot) else $error("foreign word flagged");
  property p_id; !instrValid |=> !done && !undef; endproperty
  a_id: assert property (p_id) else $error("flag without word");
  property p_zr;
    !instrValid && !loadValid ##1 $stable(readSel) |=> $stable(readData);
  endproperty
  a_zr: assert property (p_zr) else $error("read data moved with nothing written");
  cover property (g6 && !instr[4]);
  cover property (done);
  cover property (undef);
endmodule
bind ciao_int_accum ciao_int_accum_monitor mon (.clk(clk), .nrst(nrst), .instrValid(instrValid),
  .instr(instr), .loadValid(loadValid), .readSel(readSel), .readData(readData), .done(done),
  .undef(undef));
`default_nettype wire

//--- ciao_host_model.sv
// host core side: issues one word per call
// assumes calls start just after a falling edge
`timescale 1ns/1ps
`default_nettype none
module ciao_host_model (
  // clock
  input wire logic clk,
  // instruction out
  output logic instrValid,
  output logic [31:0] instr,
  // register load out
  output logic loadValid,
  output logic [3:0] loadSel,
  output logic [63:0] loadData
);
  initial
  begin
    instrValid = 1'b0;
    instr = 32'h0;
    loadValid = 1'b0;
    loadSel = 4'h0;
    loadData = 64'h0;
  end
  // load held over one rising edge, then one free cycle
  task put(input logic [3:0] sel, input logic [63:0] d);
    loadValid = 1'b1;
    loadSel = sel;
    loadData = d;
    @(negedge clk);
    loadValid = 1'b0;
    loadData = ~d;
    @(negedge clk);
  endtask
  // word held over one rising edge, then scrambled
  task send(input logic [31:0] w);
    instrValid = 1'b1;
    instr = w;
    @(negedge clk);
    instrValid = 1'b0;
    instr = ~w;
  endtask
endmodule
`default_nettype wire

//--- test_coproc_integer_accum_ops.sv
// bench for the decoder, host model on the instruction side
// assumes all registers start at zero
`timescale 1ns/1ps
`default_nettype none
module test_coproc_integer_accum_ops;
  localparam logic [63:0] OPA = 64'h8000_0001_ffff_fffe;
  localparam logic [63:0] OPB = 64'h0000_0003_8000_0003;
  localparam logic [63:0] OPC = 64'h0000_0000_7fff_0001;
  localparam logic [63:0] OPD = 64'h1234_5678_0000_0010;
  localparam logic [31:0] P32 = OPA[31:0] * OPB[31:0];
  logic clk;
  logic nrst;
  logic [3:0] readSel;
  wire instrValid;
  wire [31:0] instr;
  wire loadValid;
  wire [3:0] loadSel;
  wire [63:0] loadData;
  wire [63:0] readData;
  wire done;
  wire undef;
  int mismatches;
  int comparisons;
  ciao_host_model host (.clk(clk), .instrValid(instrValid), .instr(instr),
    .loadValid(loadValid), .loadSel(loadSel), .loadData(loadData));
  ciao_int_accum dut (.clk(clk), .nrst(nrst), .instrValid(instrValid), .instr(instr),
    .loadValid(loadValid), .loadSel(loadSel), .loadData(loadData),
    .readSel(readSel), .readData(readData), .done(done), .undef(undef));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========
  // helpers
  function logic [31:0] w(input logic [3:0] op, input logic [3:0] g, input logic [2:0] s,
    input logic b);
    return {8'hee, op, 8'h12, g, s, b, 4'h3};
  endfunction
  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task run(input logic [31:0] iw, input logic [1:0] fl, input logic [3:0] sel,
    input logic [63:0] exp);
    host.send(iw);
    check({62'h0, done, undef}, {62'h0, fl});
    readSel = sel;
    @(negedge clk);
    check(readData, exp);
  endtask
  task peek(input logic [3:0] sel, input logic [63:0] exp);
    readSel = sel;
    @(negedge clk);
    check(readData, exp);
  endtask
  task t_int();
    host.put(4'h1, OPA);
    host.put(4'h3, OPB);
    run(w(4'h3, 4'h5, 3'h1, 1'b0), 2'h2, 4'h2, 64'h0 - OPA);
    run(w(4'h3, 4'h5, 3'h2, 1'b0), 2'h2, 4'h2, {32'h0, 32'h0 - OPA[31:0]});
    run(w(4'h3, 4'h5, 3'h3, 1'b0), 2'h2, 4'h2, 64'h0 - OPA);
    run(w(4'h3, 4'h5, 3'h4, 1'b0), 2'h2, 4'h2, {32'h0, OPA[31:0] + OPB[31:0]});
    run(w(4'h3, 4'h5, 3'h5, 1'b0), 2'h2, 4'h2, OPA + OPB);
    run(w(4'h3, 4'h5, 3'h6, 1'b0), 2'h2, 4'h2, {32'h0, OPA[31:0] - OPB[31:0]});
    run(w(4'h3, 4'h5, 3'h7, 1'b0), 2'h2, 4'h2, OPA - OPB);
    host.put(4'h1, OPB);
    run(w(4'h3, 4'h5, 3'h1, 1'b0), 2'h2, 4'h2, OPB);
    $display("integer ops finished");
  endtask
  task t_mul();
    host.put(4'h1, OPA);
    run(w(4'h1, 4'h5, 3'h0, 1'b0), 2'h2, 4'h2, {32'h0, P32});
    run(w(4'h1, 4'h5, 3'h1, 1'b0), 2'h2, 4'h2, OPA * OPB);
    host.put(4'h2, OPD);
    run(w(4'h1, 4'h5, 3'h2, 1'b0), 2'h2, 4'h2, {32'h0, OPD[31:0] + P32});
    host.put(4'h2, OPD);
    run(w(4'h1, 4'h5, 3'h3, 1'b0), 2'h2, 4'h2, {32'h0, OPD[31:0] - P32});
    $display("multiply ops finished");
  endtask
  task t_acc();
    host.put(4'h2, OPD);
    host.put(4'ha, OPC);
    run(w(4'h0, 4'h6, 3'h3, 1'b0), 2'h2, 4'hb, {32'h0, OPD[31:0] + P32});
    run(w(4'h1, 4'h6, 3'h1, 1'b0), 2'h2, 4'h9, {32'h0, OPD[31:0] - P32});
    run(w(4'h2, 4'h6, 3'h0, 1'b0), 2'h2, 4'h8, {32'h0, OPC[31:0] + P32});
    run(w(4'h3, 4'h6, 3'h3, 1'b0), 2'h2, 4'hb, {32'h0, OPC[31:0] - P32});
    peek(4'ha, OPC);
    peek(4'h2, OPD);
    $display("accumulator ops finished");
  endtask
  task t_bad();
    run(w(4'h3, 4'h5, 3'h0, 1'b0), 2'h1, 4'h2, OPD);
    run(w(4'h1, 4'h5, 3'h5, 1'b0), 2'h1, 4'h2, OPD);
    run(w(4'h0, 4'h6, 3'h1, 1'b1), 2'h1, 4'h9, {32'h0, OPD[31:0] - P32});
    run(w(4'h4, 4'h6, 3'h1, 1'b0), 2'h1, 4'h9, {32'h0, OPD[31:0] - P32});
    run(32'hed000000, 2'h0, 4'h2, OPD);
    run(w(4'h3, 4'h5, 3'h4, 1'b1), 2'h0, 4'h2, OPD);
    $display("refused words finished");
  endtask
  task t_rst();
    nrst = 1'b0;
    @(negedge clk);
    @(negedge clk);
    nrst = 1'b1;
    check({63'h0, done}, 64'h0);
    peek(4'h2, 64'h0);
    peek(4'h9, 64'h0);
    $display("reset finished");
  endtask
  task end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    nrst = 1'b0;
    readSel = 4'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    t_int();
    t_mul();
    t_acc();
    t_bad();
    t_rst();
    end_of_test();
  end
  initial
  begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
